/* File: cssc_pkg.sv */
`default_nettype none
// Shared constants for the serially programmed clock synthesizer control
package cssc_pkg;

   // Clock rate and timing figures
   localparam int unsigned CLK_MHZ         = 200;        // pclk rate in MHz
   localparam int unsigned LOCK_TIME_US    = 10000;      // Lock time after a load, 10 ms
   localparam int unsigned LOCK_CYCLES     = LOCK_TIME_US * CLK_MHZ; // Longest, in pclk cycles
   localparam int unsigned REF_MIN_KHZ     = 13750;      // Lowest lockable reference
   localparam int unsigned REF_MAX_GAP_CYC = (CLK_MHZ * 1000) / REF_MIN_KHZ; // Slowest period

   // Configuration word layout, first bit shifted in sits at the top
   localparam int unsigned WORD_W     = 24;              // Serial word width
   localparam int unsigned CRYS_MSB   = 23;              // Crystal load select
   localparam int unsigned CRYS_LSB   = 22;
   localparam int unsigned DUTY_BIT   = 21;              // Duty-cycle level
   localparam int unsigned SEC_MSB    = 20;              // Secondary output select
   localparam int unsigned SEC_LSB    = 19;
   localparam int unsigned OD_MSB     = 18;              // Output divider select
   localparam int unsigned OD_LSB     = 16;
   localparam int unsigned VCO_MSB    = 15;              // VCO divider word
   localparam int unsigned VCO_LSB    = 7;
   localparam int unsigned REF_MSB    = 6;               // Reference divider word
   localparam int unsigned REF_LSB    = 0;

   // Start-up word: divide 4, VCO 8, reference 6, secondary = reference, so x1 on both
   localparam logic [23:0] CONFIG_RESET = 24'h030406;

   // Secondary output select codes
   localparam logic [1:0] SEC_REF      = 2'h0;           // Reference
   localparam logic [1:0] SEC_HALF_REF = 2'h1;           // Reference / 2
   localparam logic [1:0] SEC_OFF      = 2'h2;           // Held low
   localparam logic [1:0] SEC_HALF_PRI = 2'h3;           // Primary / 2

   // APB map (byte addresses)
   localparam logic [11:0] OFF_CONFIG = 12'h000;         // Active configuration latch
   localparam logic [11:0] OFF_STATUS = 12'h004;         // Block state

   // Status bit positions
   localparam int unsigned ST_LOCKED  = 0;               // PLL model locked
   localparam int unsigned ST_BYPASS  = 1;               // Reference divider is zero
   localparam int unsigned ST_PDOWN   = 2;               // Power-down pin is low
   localparam int unsigned ST_REFSLOW = 3;               // Reference below lock range
   localparam int unsigned ST_STROBE  = 4;               // Load strobe level

   // Output divider select to divide ratio
   function automatic logic [3:0] od_ratio(input logic [2:0] sel);
      case (sel)
         3'h0:    od_ratio = 4'hA;
         3'h1:    od_ratio = 4'h2;
         3'h2:    od_ratio = 4'h8;
         3'h3:    od_ratio = 4'h4;
         3'h4:    od_ratio = 4'h5;
         3'h5:    od_ratio = 4'h7;
         3'h6:    od_ratio = 4'h3;
         default: od_ratio = 4'h6;
      endcase
   endfunction

endpackage
`default_nettype wire

/* File: cssc_sync3.sv */
`default_nettype none
// Three-stage synchroniser; output moves once stages two and three agree
module cssc_sync3 #(
   parameter int unsigned WIDTH = 4                      // Number of independent bits
) (
   input  wire logic             clk,                    // Destination clock
   input  wire logic             rst_n,                  // Async reset, active low
   input  wire logic [WIDTH-1:0] async_in,               // Foreign-domain inputs
   output logic      [WIDTH-1:0] sync_out                // Filtered, synchronised copy
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;                              // Metastability catcher only
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] q;
   } cssc_sync_st_t;

   cssc_sync_st_t st_r;                                  // Registered state
   cssc_sync_st_t st_nxt;                                // Next state

   // Shift chain; per bit, take the value only when the late stages agree
   always_comb begin
      st_nxt    = st_r;
      st_nxt.s1 = async_in;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      for (int i = 0; i < int'(WIDTH); i++) begin
         if (st_r.s2[i] == st_r.s3[i]) begin
            st_nxt.q[i] = st_r.s3[i];
         end
      end
   end

   // State register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign sync_out = st_r.q;
endmodule // cssc_sync3
`default_nettype wire

/* File: cssc_shift_link.sv */
`default_nettype none
// Shift-clock side: holding register and a toggle per shifted bit
module cssc_shift_link (
   input  wire logic        sclk,                        // Host shift clock
   input  wire logic        presetn,                     // Async reset, active low
   input  wire logic        serial_data,                 // Serial data pin
   output logic      [23:0] holding_word,                // Shifted word, not yet active
   output logic             shift_toggle                 // Flips on every shifted bit
);
   typedef struct packed {
      logic [23:0] holding;                              // Separate from the active latch
      logic        toggle;
   } cssc_link_st_t;

   cssc_link_st_t st_r;                                  // Registered state
   cssc_link_st_t st_nxt;                                // Next state

   // Each rising shift edge pushes one bit in at the bottom
   always_comb begin
      st_nxt         = st_r;
      st_nxt.holding = {st_r.holding[22:0], serial_data}; // R15 R11
      st_nxt.toggle  = ~st_r.toggle;
   end

   // Clock stops between frames, so nothing here depends on a later edge
   always_ff @(posedge sclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign holding_word = st_r.holding;
   assign shift_toggle = st_r.toggle;

   property p_shift_in;
      @(posedge sclk) disable iff (!presetn)
      1'b1 |=> (st_r.holding[0] == $past(serial_data)) && $changed(st_r.toggle);
   endproperty
   a_shift_in: assert property (p_shift_in) // R15
      else $error("shift register did not take the data bit");
endmodule // cssc_shift_link
`default_nettype wire

/* File: cssc_top.sv */
// Local design decisions: the register offsets and the APB register port.
`default_nettype none
// What this block does
// R1 - Power up with reference on both outputs
// R2 - Default secondary output bypasses the PLL
// R3 - PLL lock only above minimum reference
// R4 - Power-down low tri-states both outputs
// R5 - Shifting and loading work during power-down
// R6 - Settings survive power-down, no default reload
// R7 - Strobe copies shifted 24-bit word into latch
// R8 - Primary output locks within 10 ms
// R9 - Shifting with strobe high updates latch live
// R10 - Host keeps strobe low while shifting; the host model holds it high through live frames
// R11 - Word order crystal first, reference LSB last
// R12 - Zero reference divider bypasses PLL, both outputs
// R13 - Secondary select: ref, ref/2, off, primary/2
// R14 - Output divider codes map to fixed ratios
// R15 - Shift register samples data on rising edge
// R16 - Latch loads on strobe rise, transparent while high
module cssc_top #(
   parameter int unsigned LOCK_CYCLES_P = cssc_pkg::LOCK_CYCLES // Lock wait in pclk cycles
) (
   input  wire logic        pclk,                        // Register clock, 200 MHz
   input  wire logic        presetn,                     // Async reset, active low
   input  wire logic [11:0] paddr,                       // APB byte address
   input  wire logic        psel,                        // APB select
   input  wire logic        penable,                     // APB access phase
   input  wire logic        pwrite,                      // APB write
   input  wire logic [31:0] pwdata,                      // APB write data
   output logic      [31:0] prdata,                      // APB read data
   output logic             pready,                      // APB ready
   output logic             pslverr,                     // APB error, unmapped address
   input  wire logic        sclk,                        // Serial shift clock
   input  wire logic        serial_data,                 // Serial data
   input  wire logic        load_strobe,                 // Load strobe
   input  wire logic        power_down_tristate_n,       // Power-down, active low
   input  wire logic        ref_clk_in,                  // Reference clock pin
   output logic             primary_clock_out,           // Primary clock level
   output logic             primary_clock_oe,            // Primary drive enable
   output logic             secondary_clock_out,         // Secondary clock level
   output logic             secondary_clock_oe,          // Secondary drive enable
   output logic      [1:0]  crystal_load_select,         // Crystal load field
   output logic             duty_level_sel,              // Duty-cycle level field
   output logic             pll_locked                   // PLL model locked
);
   import cssc_pkg::*;

   typedef struct packed {
      logic [23:0] latch;                                // Active configuration
      logic        strobe_prev;                          // Strobe edge detect
      logic        tog_prev;                             // Shift event detect
      logic        ref_prev;                             // Reference edge detect
      logic [4:0]  ref_gap;                              // Cycles since reference rise
      logic        ref_slow;                             // Reference too slow to lock
      logic [20:0] lock_cnt;                             // Settling timer
      logic        locked;
      logic [12:0] acc;                                  // Frequency synthesis accumulator
      logic        pll_phase;                            // Synthesised primary clock
      logic        half_ref;                             // Reference / 2
      logic        half_pri;                             // Primary / 2
      logic        prim;
      logic        sec;
      logic        prim_oe;
      logic        sec_oe;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } cssc_top_st_t;

   cssc_top_st_t st_r;                                   // Registered state
   cssc_top_st_t st_nxt;                                 // Next state

   logic [23:0] holding_word;                            // Shift-clock domain word
   logic        shift_toggle;                            // Shift-clock domain event
   logic [3:0]  sync_q;                                  // Synchronised pins and shift toggle
   logic        strobe_s;                                // Strobe, pclk domain
   logic        pdn_s;                                   // Power-down pin, high = running
   logic        ref_s;                                   // Reference, pclk domain
   logic        tog_s;                                   // Shift toggle, pclk domain
   logic        strobe_rise;                             // Strobe went high
   logic        tog_evt;                                 // A bit was shifted
   logic        hw_load;                                 // Latch loads from the link
   logic        sw_load;                                 // Latch loads from APB
   logic        load_any;                                // Any new configuration
   logic        ref_rise;                                // Reference rising edge
   logic        bypass;                                  // Reference divider is zero
   logic [1:0]  sec_sel;                                 // Secondary select field
   logic [12:0] acc_step;                                // 4 * (VCO word + 8)
   logic [12:0] acc_den;                                 // (Ref word + 2) * divide
   logic        prim_src;                                // Primary before gating
   logic        sec_src;                                 // Secondary before gating
   logic        apb_access;                              // First access cycle
   logic        apb_commit;                              // Edge where master samples ready
   logic [31:0] status_word;                             // Status register view

   // Shift-clock domain logic
   cssc_shift_link u_link (
      .sclk         (sclk),
      .presetn      (presetn),
      .serial_data  (serial_data),
      .holding_word (holding_word),
      .shift_toggle (shift_toggle)
   );

   // The four foreign signals cross here; holding_word is read unsynchronised, the toggle carries the shift event
   cssc_sync3 #(.WIDTH(4)) u_sync (
      .clk      (pclk),
      .rst_n    (presetn),
      .async_in ({shift_toggle, ref_clk_in, power_down_tristate_n, load_strobe}),
      .sync_out (sync_q)
   );

   assign strobe_s = sync_q[0];
   assign pdn_s    = sync_q[1];
   assign ref_s    = sync_q[2];
   assign tog_s    = sync_q[3];

   // Field decode of the active latch
   assign bypass   = (st_r.latch[REF_MSB:REF_LSB] == 7'h00);   // R12
   assign sec_sel  = st_r.latch[SEC_MSB:SEC_LSB];
   assign acc_step = 13'(({4'h0, st_r.latch[VCO_MSB:VCO_LSB]} + 13'h0008) << 2);
   assign acc_den  = 13'(({6'h00, st_r.latch[REF_MSB:REF_LSB]} + 13'h0002)
                        * {9'h000, od_ratio(st_r.latch[OD_MSB:OD_LSB])}); // R14

   // Event decode; the strobe wins over a software write in the same cycle
   assign strobe_rise = strobe_s & ~st_r.strobe_prev;
   assign tog_evt     = tog_s ^ st_r.tog_prev;
   assign ref_rise    = ref_s & ~st_r.ref_prev;
   assign hw_load     = strobe_rise | (strobe_s & tog_evt);          // R16 R9
   assign apb_access  = psel & penable & ~st_r.pready;
   assign apb_commit  = psel & penable & st_r.pready;
   assign sw_load     = apb_commit & pwrite & ~st_r.pslverr & (paddr == OFF_CONFIG);
   assign load_any    = hw_load | sw_load;

   // Status view
   always_comb begin
      status_word             = 32'h0000_0000;
      status_word[ST_LOCKED]  = st_r.locked;
      status_word[ST_BYPASS]  = bypass;
      status_word[ST_PDOWN]   = ~pdn_s;
      status_word[ST_REFSLOW] = st_r.ref_slow;
      status_word[ST_STROBE]  = strobe_s;
   end

   // Output sources before power-down gating
   always_comb begin
      prim_src = bypass ? ref_s : st_r.pll_phase;                    // R12
      case (sec_sel)
         SEC_REF:      sec_src = ref_s;                              // R2 R13
         SEC_HALF_REF: sec_src = st_r.half_ref;                      // R13
         SEC_OFF:      sec_src = 1'b0;                               // R13
         default:      sec_src = st_r.half_pri;                      // R13
      endcase
      if (bypass) begin
         sec_src = ref_s;                                            // R12
      end
   end

   // Next-state logic
   always_comb begin
      logic [13:0] acc_sum;                              // Accumulator with headroom
      acc_sum          = 14'h0000;
      st_nxt           = st_r;
      st_nxt.strobe_prev = strobe_s;
      st_nxt.tog_prev  = tog_s;
      st_nxt.ref_prev  = ref_s;

      // APB: one wait cycle, data and error prepared in the first access cycle
      st_nxt.pready = apb_access;
      if (apb_access) begin
         st_nxt.pslverr = 1'b0;
         case (paddr)
            OFF_CONFIG: st_nxt.prdata = {8'h00, st_r.latch};
            OFF_STATUS: st_nxt.prdata = status_word;
            default: begin
               st_nxt.prdata  = 32'h0000_0000;
               st_nxt.pslverr = 1'b1;
            end
         endcase
      end else if (apb_commit) begin
         st_nxt.pslverr = 1'b0;
         st_nxt.prdata  = 32'h0000_0000;
      end

      // Latch update; power-down neither blocks nor clears it
      if (hw_load) begin
         st_nxt.latch = holding_word;                                // R7 R16 R9 R5
      end else if (sw_load) begin
         st_nxt.latch = pwdata[23:0];
      end                                                            // R6

      // Reference period watch: a long gap means the PLL cannot hold lock
      if (ref_rise) begin
         st_nxt.ref_gap = 5'h00;
      end else if (st_r.ref_gap != 5'h1F) begin
         st_nxt.ref_gap = st_r.ref_gap + 5'h01;
      end
      st_nxt.ref_slow = (32'(st_r.ref_gap) > REF_MAX_GAP_CYC);       // R3

      // Lock timer restarts on every load and on leaving power-down
      if (load_any || !pdn_s || bypass || st_nxt.ref_slow) begin
         st_nxt.lock_cnt = 21'h00_0000;
         st_nxt.locked   = 1'b0;                                     // R3 R8
      end else if (st_r.lock_cnt == 21'(LOCK_CYCLES_P - 1)) begin
         st_nxt.locked   = 1'b1;                                     // R8
      end else begin
         st_nxt.lock_cnt = st_r.lock_cnt + 21'h00_0001;
      end

      // Synthesis: toggles per reference edge = step / den; at most two per edge,
      // so the model never runs faster than the reference itself
      if (pdn_s && !bypass) begin
         acc_sum = {1'b0, st_r.acc} + (ref_rise ? {1'b0, acc_step} : 14'h0000);
         if (acc_sum >= {1'b0, acc_den}) begin
            acc_sum          = acc_sum - {1'b0, acc_den};
            st_nxt.pll_phase = ~st_r.pll_phase;
         end
         if (acc_sum >= {1'b0, acc_den}) begin
            acc_sum = {1'b0, acc_den};                   // Too fast to follow, saturate
         end
         st_nxt.acc = acc_sum[12:0];
      end

      // Halved clocks for the secondary output
      if (ref_rise) begin
         st_nxt.half_ref = ~st_r.half_ref;
      end
      if (prim_src && !st_r.prim && pdn_s) begin
         st_nxt.half_pri = ~st_r.half_pri;
      end

      // Pin drive; power-down releases both pins and parks the levels low
      if (!pdn_s) begin
         st_nxt.prim    = 1'b0;
         st_nxt.sec     = 1'b0;
         st_nxt.prim_oe = 1'b0;                                      // R4
         st_nxt.sec_oe  = 1'b0;                                      // R4
      end else begin
         st_nxt.prim    = prim_src;
         st_nxt.sec     = sec_src;
         st_nxt.prim_oe = 1'b1;
         st_nxt.sec_oe  = 1'b1;
      end
   end

   // State register; the latch starts at the x1 word
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r       <= '0;
         st_r.latch <= CONFIG_RESET;                                 // R1 R2
      end else begin
         st_r <= st_nxt;
      end
   end

   // Port drive, all from flops
   assign prdata              = st_r.prdata;
   assign pready              = st_r.pready;
   assign pslverr             = st_r.pslverr;
   assign primary_clock_out   = st_r.prim;
   assign primary_clock_oe    = st_r.prim_oe;
   assign secondary_clock_out = st_r.sec;
   assign secondary_clock_oe  = st_r.sec_oe;
   assign crystal_load_select = st_r.latch[CRYS_MSB:CRYS_LSB];
   assign duty_level_sel      = st_r.latch[DUTY_BIT];
   assign pll_locked          = st_r.locked;

   // Checks
   default clocking cb_pclk @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_pdn_tristate;
      !pdn_s |=> !primary_clock_oe && !secondary_clock_oe && !primary_clock_out;
   endproperty
   a_pdn_tristate: assert property (p_pdn_tristate) // R4
      else $error("outputs driven during power-down");

   property p_strobe_load;
      strobe_rise |=> st_r.latch == $past(holding_word);
   endproperty
   a_strobe_load: assert property (p_strobe_load) // R7
      else $error("strobe rise did not load the word");

   property p_transparent;
      strobe_s && tog_evt |=> st_r.latch == $past(holding_word);
   endproperty
   a_transparent: assert property (p_transparent) // R9
      else $error("latch not transparent while strobe high");

   property p_load_in_pdn;
      !pdn_s && strobe_rise |=> st_r.latch == $past(holding_word) && !primary_clock_oe;
   endproperty
   a_load_in_pdn: assert property (p_load_in_pdn) // R5
      else $error("load refused during power-down");

   property p_keep_cfg;
      !load_any |=> $stable(st_r.latch);
   endproperty
   a_keep_cfg: assert property (p_keep_cfg) // R6
      else $error("configuration changed without a load");

   property p_lock_restart;
      load_any |=> !pll_locked [*2];
   endproperty
   a_lock_restart: assert property (p_lock_restart) // R8
      else $error("lock held across a new load");

   property p_lock_time;
      $rose(pll_locked) |-> st_r.lock_cnt == 21'(LOCK_CYCLES_P - 1);
   endproperty
   a_lock_time: assert property (p_lock_time) // R8
      else $error("lock reported before settling time");

   property p_ref_slow;
      st_r.ref_slow |-> !pll_locked;
   endproperty
   a_ref_slow: assert property (p_ref_slow) // R3
      else $error("lock reported with slow reference");

   property p_bypass_follow;
      bypass && pdn_s && $stable(st_r.latch) |=> primary_clock_out == $past(ref_s)
         && secondary_clock_out == $past(ref_s);
   endproperty
   a_bypass_follow: assert property (p_bypass_follow) // R12
      else $error("bypass does not pass the reference");

   property p_sec_ref;
      !bypass && pdn_s && sec_sel == SEC_REF |=> secondary_clock_out == $past(ref_s);
   endproperty
   a_sec_ref: assert property (p_sec_ref) // R2
      else $error("secondary does not follow reference");

   property p_sec_off;
      !bypass && sec_sel == SEC_OFF |=> !secondary_clock_out;
   endproperty
   a_sec_off: assert property (p_sec_off) // R13
      else $error("secondary not held low when off");

   c_strobe_load: cover property (strobe_rise ##1 !strobe_s);
   c_locked:      cover property ($rose(pll_locked));
   c_pdn_exit:    cover property (!pdn_s ##1 pdn_s);
   c_bypass:      cover property (bypass && pdn_s);
endmodule // cssc_top
`default_nettype wire

/* File: cssc_host_model.sv */
`default_nettype none
// Host end of the three-wire link; shift clock idles low between frames
module cssc_host_model (
   output logic sclk,                                    // Shift clock
   output logic serial_data,                             // Serial data
   output logic load_strobe                              // Load strobe
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      sclk = 1'b0;
      serial_data = 1'b0;
      load_strobe = 1'b0;
   end
   // One frame, first bit at the top; strobe stays low until all 24 are in
   // Live frames hold the strobe high throughout, on purpose
   task automatic send(input logic [23:0] w, input logic live);
      load_strobe = live;
      for (int i = 23; i >= 0; i--) begin
         serial_data = w[i];
         #32 sclk = 1'b1;
         #32 sclk = 1'b0;
      end
      serial_data = ~w[0]; // Released line must not look like a held bit
      #32 load_strobe = 1'b1;
      #64 load_strobe = 1'b0;
   endtask
endmodule // cssc_host_model
`default_nettype wire

/* File: clock_synth_serial_config_tb.sv */
`default_nettype none
module clock_synth_serial_config_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import cssc_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pdn_n, refc, sclk, sd, stb, e;
   logic ref_run = 1'b1; // Reference runs while high
   logic [11:0] paddr;
   logic [31:0] pwdata, q, prdata;
   logic pready, pslverr, p_out, p_oe, s_out, s_oe, duty, lock;
   logic [1:0] crys;
   int errors = 0;
   int n_compared = 0;
   cssc_top #(.LOCK_CYCLES_P(20)) dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .sclk(sclk), .serial_data(sd), .load_strobe(stb),
      .power_down_tristate_n(pdn_n), .ref_clk_in(refc), .primary_clock_out(p_out),
      .primary_clock_oe(p_oe), .secondary_clock_out(s_out), .secondary_clock_oe(s_oe),
      .crystal_load_select(crys), .duty_level_sel(duty), .pll_locked(lock));
   cssc_host_model host (.sclk(sclk), .serial_data(sd), .load_strobe(stb));
   // Clocks: 5 ns bus clock, 30 ns reference inside the lock range
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   initial begin
      refc = 1'b0;
      forever #15 refc = ~refc & ref_run;
   end
   task automatic test_done;
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // One APB transfer, held until pready is seen high
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         errors++;
         test_done();
      end
      q = prdata;
      e = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   // Rising edges of both outputs over 60 cycles, ten reference periods
   task automatic rises(output logic [31:0] r);
      logic pp, sp;
      r = 32'h0;
      @(negedge pclk);
      {pp, sp} = {p_out, s_out};
      repeat (60) begin
         @(negedge pclk);
         r[31:16] += 16'(p_out & ~pp);
         r[15:0] += 16'(s_out & ~sp);
         {pp, sp} = {p_out, s_out};
      end
   endtask
   task automatic t_reset;
      apb(OFF_CONFIG, 1'b0, 32'h0);
      chk(q, {8'h00, CONFIG_RESET});
      chk({31'h0, p_oe & s_oe}, 32'h1);
      rises(q);
      chk(q, 32'h000A_000A);
   endtask
   // Serial load, then lock within 100 pclk cycles of the readback; secondary off
   task automatic t_load;
      int n;
      host.send(24'h318A3B, 1'b0);
      repeat (10) @(posedge pclk);
      apb(OFF_CONFIG, 1'b0, 32'h0);
      chk(q, 32'h00318A3B);
      chk({29'h0, crys, duty}, 32'h1);
      for (n = 0; n < 100 && lock !== 1'b1; n++) @(posedge pclk);
      chk({31'h0, lock}, 32'h1);
      if (lock !== 1'b1) test_done();
      for (n = 0; n < 20; n++) @(negedge pclk) chk({31'h0, s_out}, 32'h0);
   endtask
   // Reference stopped: the slow flag rises and lock drops
   task automatic t_slow;
      @(posedge pclk);
      ref_run <= 1'b0;
      repeat (40) @(posedge pclk);
      apb(OFF_STATUS, 1'b0, 32'h0);
      chk({30'h0, q[ST_REFSLOW], q[ST_LOCKED]}, 32'h2);
      ref_run <= 1'b1;
   endtask
   // Load during power-down; settings survive exit
   task automatic t_pdown;
      @(posedge pclk);
      pdn_n <= 1'b0;
      repeat (10) @(posedge pclk);
      chk({30'h0, p_oe, s_oe}, 32'h0);
      host.send(24'h318A00, 1'b0);
      repeat (10) @(posedge pclk);
      pdn_n <= 1'b1;
      repeat (10) @(posedge pclk);
      apb(OFF_CONFIG, 1'b0, 32'h0);
      chk(q, 32'h00318A00);
      apb(OFF_STATUS, 1'b0, 32'h0);
      chk({31'h0, q[ST_BYPASS]}, 32'h1);
      chk({31'h0, p_oe}, 32'h1);
      rises(q);
      chk(q, 32'h000A_000A);
      apb(12'h008, 1'b1, 32'h0);
      chk({31'h0, e}, 32'h1);
   endtask
   // Strobe high while shifting: latch follows each bit; then a bus write
   task automatic t_live;
      host.send(CONFIG_RESET, 1'b1);
      repeat (10) @(posedge pclk);
      apb(OFF_CONFIG, 1'b0, 32'h0);
      chk(q, {8'h00, CONFIG_RESET});
      rises(q);
      chk(q, 32'h000A_000A);
      apb(OFF_CONFIG, 1'b1, 32'h0031_8A3B);
      apb(OFF_CONFIG, 1'b0, 32'h0);
      chk(q, 32'h0031_8A3B);
   endtask
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      pdn_n = 1'b1;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      repeat (10) @(posedge pclk);
      t_reset();
      t_load();
      t_slow();
      t_pdown();
      t_live();
      test_done();
   end
   // Hang guard
   initial begin
      #200us;
      errors++;
      test_done();
   end
endmodule // clock_synth_serial_config_tb
`default_nettype wire
